// ===== src/ext_bus_pkg.sv
// package: constants for the external bus and port pin control block
package ext_bus_pkg;
	localparam int unsigned PORT_COUNT       = 6;
	localparam int unsigned PORT_WIDTH       = 8;
	localparam int unsigned IDX_P0           = 0;
	localparam int unsigned IDX_P1           = 1;
	localparam int unsigned IDX_P2           = 2;
	localparam int unsigned IDX_P3           = 3;
	localparam int unsigned IDX_P5           = 4;
	localparam int unsigned IDX_P6           = 5;
	localparam logic [7:0]  OFS_PORT_STRIDE  = 8'h08;
	localparam logic [7:0]  OFS_DIR_DELTA    = 8'h04;
	localparam logic [7:0]  OFS_PORT4        = 8'h30;
	localparam logic [7:0]  OFS_MODE         = 8'h34;
	localparam logic [7:0]  OFS_P3_ALT       = 8'h38;
	localparam logic [7:0]  OFS_P6_IRQ       = 8'h3C;
	localparam logic [7:0]  OFS_DBB_IN       = 8'h40;
	localparam logic [7:0]  OFS_DBB_OUT      = 8'h44;
	localparam logic [7:0]  OFS_DBB_STAT     = 8'h48;
	localparam logic [7:0]  OFS_BUS_STAT     = 8'h4C;
	localparam logic [7:0]  RST_PORT_DATA    = 8'h00;
	localparam logic [7:0]  RST_PORT_DIR     = 8'h00;
	localparam logic [7:0]  RST_P3_ALT       = 8'h00;
	localparam logic [2:0]  RST_P6_IRQ       = 3'h0;
	localparam int unsigned MODE_SLAVE_BIT   = 0;
	localparam int unsigned STAT_OBF_BIT     = 0;
	localparam int unsigned STAT_IBF_BIT     = 1;
	localparam int unsigned STAT_CMD_BIT     = 2;
	localparam int unsigned BUSST_EXP_BIT    = 0;
	localparam int unsigned BUSST_BUSY_BIT   = 1;
	localparam int unsigned MCTL_SEL_BIT     = 3;
	localparam int unsigned MCTL_RD_BIT      = 4;
	localparam int unsigned MCTL_WR_BIT      = 5;
	localparam int unsigned MCTL_A0_BIT      = 6;
	localparam logic [15:0] INT_WINDOW_TOP   = 16'h00FF;
	localparam int unsigned PHI_DIVIDE       = 4;
	localparam int unsigned CLK_PERIOD_PS    = 4000;
	localparam int unsigned RESET_MIN_NS     = 2000;
	localparam int unsigned RESET_MIN_CYCLES =
		(RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ADDR   = 2'b01,
		BUS_STROBE = 2'b10,
		BUS_DONE   = 2'b11
	} bus_state_e;
endpackage

// ===== src/ext_bus_pins.sv
// module: pin-level external bus, general ports and master cpu data bus buffer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - timing clock is oscillator divided by four
// - fetch indicator high during opcode fetch
// - direction output high read, low write
// - per-bit direction registers, push-pull outputs
// - expanded mode: port zero carries low address
// - expanded mode: port one carries high address
// - expanded mode: port two is data bus
// - port three bits select alternate functions
// - port four input only, three or eight
// - slave mode: port five master data bus
// - slave mode: port six bits 3-7 control
// - port six low bits as interrupts
// - large package: active-low read strobe
// - large package: active-low write strobe
// - large package: reset output high in reset
// - mode pin selects single-chip or expanded
// - one byte buffer each direction
// - registers and memory share one map
module ext_bus_pins #(
	parameter bit LARGE_PACKAGE = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        core_req,
	input  wire logic        core_we,
	input  wire logic        core_fetch,
	input  wire logic [15:0] core_addr,
	input  wire logic [7:0]  core_wdata,
	output logic      [7:0]  core_rdata,
	output logic             core_ack,
	input  wire logic        processor_mode_select_pin,
	output logic             timing_clock_out,
	output logic             opcode_fetch_out,
	output logic             read_write_out,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             reset_out,
	input  wire logic [7:0]  port_zero_lines_in,
	output logic      [7:0]  port_zero_lines_out,
	output logic      [7:0]  port_zero_lines_oe,
	input  wire logic [7:0]  port_one_lines_in,
	output logic      [7:0]  port_one_lines_out,
	output logic      [7:0]  port_one_lines_oe,
	input  wire logic [7:0]  port_two_lines_in,
	output logic      [7:0]  port_two_lines_out,
	output logic      [7:0]  port_two_lines_oe,
	input  wire logic [7:0]  port_three_lines_in,
	output logic      [7:0]  port_three_lines_out,
	output logic      [7:0]  port_three_lines_oe,
	input  wire logic [7:0]  p3_alt_out,
	input  wire logic [7:0]  p3_alt_oe,
	input  wire logic [7:0]  port_four_inputs,
	input  wire logic [7:0]  port_five_lines_in,
	output logic      [7:0]  port_five_lines_out,
	output logic      [7:0]  port_five_lines_oe,
	input  wire logic [7:0]  port_six_lines_in,
	output logic      [7:0]  port_six_lines_out,
	output logic      [7:0]  port_six_lines_oe,
	output logic      [2:0]  ext_irq_req
);
	import ext_bus_pkg::*;

	logic [7:0] port_data [PORT_COUNT];
	logic [7:0] port_dir [PORT_COUNT];
	logic [7:0] pin_in [PORT_COUNT];
	logic [7:0] pin_out [PORT_COUNT];
	logic [7:0] pin_oe [PORT_COUNT];
	logic [7:0] next_out [PORT_COUNT];
	logic [7:0] next_oe [PORT_COUNT];
	logic [7:0] p3_alt_sel;
	logic [2:0] p6_irq_en;
	logic       slave_en;
	logic       expanded;
	logic [1:0] phi_count;
	logic       phi_tick;
	bus_state_e bus_state;
	logic [15:0] ext_addr;
	logic       ext_we;
	logic [7:0] ext_wdata;
	logic [7:0] ext_rdata;
	logic [7:0] dbb_in;
	logic [7:0] dbb_out;
	logic       ibf;
	logic       obf;
	logic       cmd_flag;
	logic       m_rd_q;
	logic       m_wr_q;
	logic [7:0] port4_mask;

	assign pin_in[IDX_P0] = port_zero_lines_in;
	assign pin_in[IDX_P1] = port_one_lines_in;
	assign pin_in[IDX_P2] = port_two_lines_in;
	assign pin_in[IDX_P3] = port_three_lines_in;
	assign pin_in[IDX_P5] = port_five_lines_in;
	assign pin_in[IDX_P6] = port_six_lines_in;
	assign port_zero_lines_out  = pin_out[IDX_P0];
	assign port_zero_lines_oe   = pin_oe[IDX_P0];
	assign port_one_lines_out   = pin_out[IDX_P1];
	assign port_one_lines_oe    = pin_oe[IDX_P1];
	assign port_two_lines_out   = pin_out[IDX_P2];
	assign port_two_lines_oe    = pin_oe[IDX_P2];
	assign port_three_lines_out = pin_out[IDX_P3];
	assign port_three_lines_oe  = pin_oe[IDX_P3];
	assign port_five_lines_out  = pin_out[IDX_P5];
	assign port_five_lines_oe   = pin_oe[IDX_P5];
	assign port_six_lines_out   = pin_out[IDX_P6];
	assign port_six_lines_oe    = pin_oe[IDX_P6];
	// small package bonds out only three port four pins
	assign port4_mask = LARGE_PACKAGE ? 8'hFF : 8'h07;

	// master control lines, active low except the data/status select
	logic m_sel;
	logic m_rd;
	logic m_wr;
	logic m_a0;
	assign m_sel = slave_en & ~pin_in[IDX_P6][MCTL_SEL_BIT];
	assign m_rd  = m_sel & ~pin_in[IDX_P6][MCTL_RD_BIT];
	assign m_wr  = m_sel & ~pin_in[IDX_P6][MCTL_WR_BIT];
	assign m_a0  = pin_in[IDX_P6][MCTL_A0_BIT];

	// apb: no wait state, answer registered in the access phase
	logic apb_setup;
	logic apb_done;
	logic apb_wr;
	logic apb_rd;
	assign apb_setup = psel & ~penable;
	assign apb_done  = psel & penable & pready;
	assign apb_wr    = apb_done & pwrite;
	assign apb_rd    = apb_done & ~pwrite;

	// core access routing within the common map
	logic core_int;
	logic core_ext;
	logic core_idle_ok;
	assign core_int = core_addr <= INT_WINDOW_TOP;
	assign core_ext = expanded & ~core_int;
	assign core_idle_ok = core_req & ~core_ack & bus_state == BUS_IDLE;

	function automatic logic reg_hit(input logic [7:0] ofs);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < PORT_COUNT; k++) begin
			if (ofs == 8'(k) * OFS_PORT_STRIDE || ofs == 8'(k) * OFS_PORT_STRIDE + OFS_DIR_DELTA)
				hit = 1'b1;
		end
		if (ofs >= OFS_PORT4 && ofs <= OFS_BUS_STAT && ofs[1:0] == 2'b00)
			hit = 1'b1;
		return hit;
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] ofs);
		logic [7:0] val;
		val = 8'h00;
		for (int k = 0; k < PORT_COUNT; k++) begin
			if (ofs == 8'(k) * OFS_PORT_STRIDE)
				val = (port_data[k] & port_dir[k]) | (pin_in[k] & ~port_dir[k]);
			else if (ofs == 8'(k) * OFS_PORT_STRIDE + OFS_DIR_DELTA)
				val = port_dir[k];
		end
		if (ofs == OFS_PORT4)
			val = port_four_inputs & port4_mask;
		else if (ofs == OFS_MODE)
			val = {7'h00, slave_en};
		else if (ofs == OFS_P3_ALT)
			val = p3_alt_sel;
		else if (ofs == OFS_P6_IRQ)
			val = {5'h00, p6_irq_en};
		else if (ofs == OFS_DBB_IN)
			val = dbb_in;
		else if (ofs == OFS_DBB_OUT)
			val = dbb_out;
		else if (ofs == OFS_DBB_STAT)
			val = {5'h00, cmd_flag, ibf, obf};
		else if (ofs == OFS_BUS_STAT)
			val = {6'h00, bus_state != BUS_IDLE, expanded};
		return val;
	endfunction

	// shared write port: apb first, core internal writes wait a cycle
	logic       wr_en;
	logic [7:0] wr_ofs;
	logic [7:0] wr_val;
	logic       core_int_go;
	assign core_int_go = core_idle_ok & ~core_ext & ~apb_wr;
	always_comb begin
		wr_en  = 1'b0;
		wr_ofs = paddr;
		wr_val = pwdata[7:0];
		if (apb_wr) begin
			wr_en = 1'b1;
		end else if (core_int_go && core_we && core_int) begin
			wr_en  = 1'b1;
			wr_ofs = core_addr[7:0];
			wr_val = core_wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup & ~reg_hit(paddr);
			if (apb_setup)
				prdata <= {24'h000000, reg_read(paddr)};
		end
	end

	generate
		for (genvar k = 0; k < PORT_COUNT; k++) begin : g_port_regs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_data[k] <= RST_PORT_DATA;
					port_dir[k]  <= RST_PORT_DIR;
				end else if (wr_en) begin
					if (wr_ofs == 8'(k) * OFS_PORT_STRIDE)
						port_data[k] <= wr_val;
					if (wr_ofs == 8'(k) * OFS_PORT_STRIDE + OFS_DIR_DELTA)
						port_dir[k] <= wr_val;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_en   <= 1'b0;
			p3_alt_sel <= RST_P3_ALT;
			p6_irq_en  <= RST_P6_IRQ;
		end else if (wr_en) begin
			if (wr_ofs == OFS_MODE)
				slave_en <= wr_val[MODE_SLAVE_BIT];
			if (wr_ofs == OFS_P3_ALT)
				p3_alt_sel <= wr_val;
			if (wr_ofs == OFS_P6_IRQ)
				p6_irq_en <= wr_val[2:0];
		end
	end

	// mode strap is followed continuously, never caught under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			expanded <= 1'b0;
		else
			expanded <= processor_mode_select_pin;
	end

	// timing clock divider and bus-cycle enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phi_count        <= 2'b00;
			timing_clock_out <= 1'b0;
		end else begin
			phi_count        <= phi_count + 2'b01;
			timing_clock_out <= ~phi_count[1];
		end
	end
	assign phi_tick = phi_count == 2'(PHI_DIVIDE - 1);

	// external bus cycle, one phase per timing clock period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state <= BUS_IDLE;
			ext_addr  <= 16'h0000;
			ext_we    <= 1'b0;
			ext_wdata <= 8'h00;
			ext_rdata <= 8'h00;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (core_idle_ok && core_ext) begin
						bus_state <= BUS_ADDR;
						ext_addr  <= core_addr;
						ext_we    <= core_we;
						ext_wdata <= core_wdata;
					end
				end
				BUS_ADDR: begin
					if (phi_tick)
						bus_state <= BUS_STROBE;
				end
				BUS_STROBE: begin
					if (phi_tick) begin
						bus_state <= BUS_DONE;
						ext_rdata <= pin_in[IDX_P2];
					end
				end
				BUS_DONE: begin
					bus_state <= BUS_IDLE;
				end
				default: begin
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ack   <= 1'b0;
			core_rdata <= 8'h00;
		end else begin
			core_ack <= 1'b0;
			if (bus_state == BUS_DONE) begin
				core_ack   <= 1'b1;
				core_rdata <= ext_we ? 8'h00 : ext_rdata;
			end else if (core_int_go) begin
				core_ack   <= 1'b1;
				core_rdata <= core_int ? reg_read(core_addr[7:0]) : 8'h00;
			end
		end
	end

	// strobes and direction, registered straight to the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcode_fetch_out <= 1'b0;
			read_write_out   <= 1'b1;
			read_strobe_n    <= 1'b1;
			write_strobe_n   <= 1'b1;
		end else begin
			opcode_fetch_out <= core_req & core_fetch & ~core_ack;
			read_write_out   <= ~(bus_state != BUS_IDLE && ext_we);
			read_strobe_n    <= ~(LARGE_PACKAGE && bus_state == BUS_STROBE && !ext_we);
			write_strobe_n   <= ~(LARGE_PACKAGE && bus_state == BUS_STROBE && ext_we);
		end
	end

	// held high while reset is applied in the large package (low throughout in the small one), drops at the first edge after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			reset_out <= LARGE_PACKAGE;
		else
			reset_out <= 1'b0;
	end

	// pin drive selection
	always_comb begin
		for (int k = 0; k < PORT_COUNT; k++) begin
			next_out[k] = port_data[k];
			next_oe[k]  = port_dir[k];
		end
		if (expanded) begin
			next_out[IDX_P0] = ext_addr[7:0];
			next_oe[IDX_P0]  = 8'hFF;
			next_out[IDX_P1] = ext_addr[15:8];
			next_oe[IDX_P1]  = 8'hFF;
			next_out[IDX_P2] = ext_wdata;
			next_oe[IDX_P2]  = (bus_state != BUS_IDLE && ext_we) ? 8'hFF : 8'h00;
		end
		for (int b = 0; b < PORT_WIDTH; b++) begin
			if (p3_alt_sel[b]) begin
				next_out[IDX_P3][b] = p3_alt_out[b];
				next_oe[IDX_P3][b]  = p3_alt_oe[b];
			end
		end
		if (slave_en) begin
			next_out[IDX_P5] = m_a0 ? {5'h00, cmd_flag, ibf, obf} : dbb_out;
			next_oe[IDX_P5]  = m_rd ? 8'hFF : 8'h00;
			next_oe[IDX_P6][7:3] = 5'h00;
		end
		for (int b = 0; b < 3; b++) begin
			if (p6_irq_en[b])
				next_oe[IDX_P6][b] = 1'b0;
		end
	end

	generate
		for (genvar k = 0; k < PORT_COUNT; k++) begin : g_pin_regs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_out[k] <= RST_PORT_DATA;
					pin_oe[k]  <= 8'h00;
				end else begin
					pin_out[k] <= next_out[k];
					pin_oe[k]  <= next_oe[k];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_irq_req <= 3'h0;
		else
			ext_irq_req <= pin_in[IDX_P6][2:0] & p6_irq_en;
	end

	// master data bus buffer; a set always wins over a same-cycle clear
	logic m_wr_end;
	logic m_rd_end;
	assign m_wr_end = m_wr_q & ~m_wr;
	assign m_rd_end = m_rd_q & ~m_rd & ~m_a0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_rd_q   <= 1'b0;
			m_wr_q   <= 1'b0;
			dbb_in   <= 8'h00;
			dbb_out  <= 8'h00;
			ibf      <= 1'b0;
			obf      <= 1'b0;
			cmd_flag <= 1'b0;
		end else begin
			m_rd_q <= m_rd;
			m_wr_q <= m_wr;
			if (m_wr_end) begin
				dbb_in   <= pin_in[IDX_P5];
				cmd_flag <= m_a0;
				ibf      <= 1'b1;
			end else if (apb_rd && paddr == OFS_DBB_IN) begin
				ibf <= 1'b0;
			end
			if (wr_en && wr_ofs == OFS_DBB_OUT) begin
				dbb_out <= wr_val;
				obf     <= 1'b1;
			end else if (m_rd_end) begin
				obf <= 1'b0;
			end
		end
	end

	chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		apb_setup |=> pready && psel && penable)
		else $error("apb access phase not answered in one cycle");
	chk_phi_period: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(timing_clock_out) |-> ##4 $rose(timing_clock_out))
		else $error("timing clock period is not four cycles");
	chk_phi_duty: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(timing_clock_out) |=> timing_clock_out ##1 !timing_clock_out [*2])
		else $error("timing clock duty is not half");
	chk_reset_out_low: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> !reset_out)
		else $error("reset output high after reset release");
	chk_write_dir: assert property (@(posedge pclk) disable iff (!presetn)
		!write_strobe_n |-> !read_write_out && port_two_lines_oe == 8'hFF)
		else $error("write strobe without write direction or drive");
	chk_read_dir: assert property (@(posedge pclk) disable iff (!presetn)
		!read_strobe_n |-> read_write_out && port_two_lines_oe == 8'h00)
		else $error("read strobe while data bus driven");
	chk_single_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!expanded [*3] |-> read_strobe_n && write_strobe_n && read_write_out)
		else $error("bus activity in single-chip mode");
	chk_ext_cycle_len: assert property (@(posedge pclk) disable iff (!presetn)
		bus_state == BUS_IDLE ##1 bus_state == BUS_ADDR |-> ##[1:8] bus_state == BUS_DONE)
		else $error("external cycle overran two timing periods");
	chk_ibf_set: assert property (@(posedge pclk) disable iff (!presetn)
		m_wr_end |=> ibf && dbb_in == $past(port_five_lines_in))
		else $error("master write not captured in input buffer");
	chk_obf_set: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == OFS_DBB_OUT |=> obf)
		else $error("output buffer flag not set on load");
	chk_fetch_flag: assert property (@(posedge pclk) disable iff (!presetn)
		core_req && core_fetch && !core_ack |=> opcode_fetch_out)
		else $error("fetch indicator missing during fetch");
	cov_ext_read: cover property (@(posedge pclk) disable iff (!presetn)
		!read_strobe_n ##[1:8] core_ack);
	cov_ext_write: cover property (@(posedge pclk) disable iff (!presetn)
		!write_strobe_n ##[1:8] core_ack);
	cov_master_write: cover property (@(posedge pclk) disable iff (!presetn) m_wr_end);
	cov_master_read: cover property (@(posedge pclk) disable iff (!presetn) obf ##1 m_rd_end);
endmodule // ext_bus_pins
`default_nettype wire

// ===== test/ext_mem_model.sv
// external memory partner sitting on the expanded address and data bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input  wire logic       pclk,
	input  wire logic       expanded,
	input  wire logic [7:0] addr_lo,
	input  wire logic [7:0] wdata,
	input  wire logic       read_strobe_n,
	input  wire logic       write_strobe_n,
	output logic      [7:0] rdata,
	output logic            drive_en
);
	logic [7:0] mem [256];
	logic [7:0] last;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		last = 8'h00;
	end
	// the bus belongs to this side only outside single-chip operation
	assign drive_en = expanded;
	// released bus shows the inverse of the last byte so stale data cannot pass
	assign rdata = !read_strobe_n ? mem[addr_lo] : ~last;
	always @(posedge pclk) begin
		if (!read_strobe_n)
			last <= mem[addr_lo];
		if (!write_strobe_n)
			mem[addr_lo] <= wdata;
	end
endmodule // ext_mem_model
`default_nettype wire

// ===== test/external_bus_pin_control_test.sv
// self-checking bench for the external bus and port pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module external_bus_pin_control_test;
	import ext_bus_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_pin;
	logic        core_req, core_we, core_fetch, core_ack, p2_en, reset_out;
	logic        timing_clock_out, opcode_fetch_out, read_write_out;
	logic        read_strobe_n, write_strobe_n, sr, sw, sl, sf;
	logic [7:0]  paddr, core_wdata, core_rdata, p3_alt_out, p3_alt_oe, port_four_inputs;
	logic [7:0]  p2_mem, alo, ahi, p2o, crd, r8;
	logic [31:0] pwdata, prdata;
	logic [15:0] core_addr;
	logic [2:0]  ext_irq_req;
	logic [7:0]  pin_in [6];
	logic [7:0]  p_out [6];
	logic [7:0]  p_oe [6];
	int          fails, n_checks;

	ext_bus_pins #(.LARGE_PACKAGE(1'b1)) i_ext_bus_pins (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_req(core_req), .core_we(core_we),
		.core_fetch(core_fetch), .core_addr(core_addr), .core_wdata(core_wdata),
		.core_rdata(core_rdata), .core_ack(core_ack),
		.processor_mode_select_pin(mode_pin), .timing_clock_out(timing_clock_out),
		.opcode_fetch_out(opcode_fetch_out), .read_write_out(read_write_out),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.reset_out(reset_out),
		.port_zero_lines_in(pin_in[0]), .port_zero_lines_out(p_out[0]),
		.port_zero_lines_oe(p_oe[0]), .port_one_lines_in(pin_in[1]),
		.port_one_lines_out(p_out[1]), .port_one_lines_oe(p_oe[1]),
		.port_two_lines_in(p2_en ? p2_mem : pin_in[2]),
		.port_two_lines_out(p_out[2]), .port_two_lines_oe(p_oe[2]),
		.port_three_lines_in(pin_in[3]), .port_three_lines_out(p_out[3]),
		.port_three_lines_oe(p_oe[3]), .p3_alt_out(p3_alt_out), .p3_alt_oe(p3_alt_oe),
		.port_four_inputs(port_four_inputs), .port_five_lines_in(pin_in[4]),
		.port_five_lines_out(p_out[4]), .port_five_lines_oe(p_oe[4]),
		.port_six_lines_in(pin_in[5]), .port_six_lines_out(p_out[5]),
		.port_six_lines_oe(p_oe[5]), .ext_irq_req(ext_irq_req)
	);

	ext_mem_model i_ext_mem_model (
		.pclk(pclk), .expanded(mode_pin), .addr_lo(p_out[0]), .wdata(p_out[2]),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.rdata(p2_mem), .drive_en(p2_en)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, d, output logic [7:0] rd,
		output logic err);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			fails++;
			stop_test();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rchk(input logic [7:0] a, e, input string nm);
		logic [7:0] r;
		logic       x;
		apb(1'b0, a, 8'h00, r, x);
		`CHK(nm, e, r)
	endtask

	task automatic core(input logic we, f, input logic [15:0] a, input logic [7:0] d);
		int i;
		{sr, sw, sl, sf} = 4'h0;
		@(posedge pclk);
		core_req   <= 1'b1;
		core_we    <= we;
		core_fetch <= f;
		core_addr  <= a;
		core_wdata <= d;
		i = 0;
		do begin
			@(posedge pclk);
			#1;
			i++;
			sr |= !read_strobe_n;
			sw |= !write_strobe_n;
			sl |= !read_write_out;
			sf |= opcode_fetch_out;
			if (!(read_strobe_n && write_strobe_n)) begin
				alo = p_out[0];
				ahi = p_out[1];
				p2o = p_oe[2];
			end
		end while (core_ack !== 1'b1 && i < 40);
		if (i >= 40) begin
			fails++;
			stop_test();
		end
		crd = core_rdata;
		@(posedge pclk);
		core_req <= 1'b0;
		@(posedge pclk);
	endtask

	initial begin
		int   rises;
		int   highs;
		logic prev;
		logic e;
		{presetn, psel, penable, pwrite, core_req, core_we, core_fetch} = 7'h00;
		mode_pin = 1'b0;
		{paddr, core_wdata, pwdata, core_addr} = '0;
		{p3_alt_out, p3_alt_oe, port_four_inputs} = {8'h5A, 8'h30, 8'hA7};
		pin_in = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h78};
		repeat (3) @(posedge pclk);
		#1;
		`CHK("reset_out in reset", 1'b1, reset_out)
		`CHK("strobes in reset", 2'b11, {read_strobe_n, write_strobe_n})
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		`CHK("reset_out after", 1'b0, reset_out)
		$display("test reset done");
		rises = 0;
		highs = 0;
		prev = timing_clock_out;
		repeat (16) begin
			@(posedge pclk);
			#1;
			rises += int'(timing_clock_out && !prev);
			highs += int'(timing_clock_out);
			prev = timing_clock_out;
		end
		`CHK("clock rises", 4, rises)
		`CHK("clock highs", 8, highs)
		$display("test clock done");
		for (int k = 0; k < 6; k++) begin
			wr(8'(8 * k + 4), 8'h0F);
			wr(8'(8 * k), 8'hA5);
			rchk(8'(8 * k), 8'h05 | (pin_in[k] & 8'hF0), "port data");
			@(posedge pclk);
			#1;
			`CHK("port oe", 8'h0F, p_oe[k])
			`CHK("port out", 8'h05, p_out[k] & 8'h0F)
		end
		$display("test ports done");
		apb(1'b0, 8'h50, 8'h00, r8, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 8'h00, r8)
		wr(OFS_PORT4, 8'h00);
		rchk(OFS_PORT4, 8'hA7, "port four");
		wr(OFS_P3_ALT, 8'hF0);
		@(posedge pclk);
		#1;
		`CHK("p3 alt oe", 8'h3F, p_oe[3])
		`CHK("p3 alt out", 8'h55, p_out[3])
		wr(OFS_P6_IRQ, 8'h05);
		pin_in[5] <= 8'h7F;
		repeat (2) @(posedge pclk);
		#1;
		`CHK("irq on", 3'h5, ext_irq_req)
		pin_in[5] <= 8'h78;
		repeat (2) @(posedge pclk);
		#1;
		`CHK("irq off", 3'h0, ext_irq_req)
		core(1'b0, 1'b1, 16'h1234, 8'h00);
		`CHK("single-chip far read", 2'b00, {crd, sr} == 9'h000 ? 2'b00 : 2'b11)
		$display("test single-chip done");
		wr(OFS_MODE, 8'h01);
		pin_in[4] <= 8'h5A;
		pin_in[5] <= 8'h10;
		repeat (2) @(posedge pclk);
		pin_in[5] <= 8'h30;
		repeat (2) @(posedge pclk);
		pin_in[5] <= 8'h78;
		rchk(OFS_DBB_STAT, 8'h02, "ibf set");
		rchk(OFS_DBB_IN, 8'h5A, "dbb in");
		wr(OFS_DBB_OUT, 8'hC3);
		rchk(OFS_DBB_STAT, 8'h01, "obf set");
		pin_in[5] <= 8'h60;
		repeat (3) @(posedge pclk);
		#1;
		`CHK("master status oe", 8'hFF, p_oe[4])
		`CHK("master status", 8'h01, p_out[4])
		pin_in[5] <= 8'h20;
		repeat (3) @(posedge pclk);
		#1;
		`CHK("master data", 8'hC3, p_out[4])
		pin_in[5] <= 8'h30;
		repeat (2) @(posedge pclk);
		pin_in[5] <= 8'h78;
		rchk(OFS_DBB_STAT, 8'h00, "obf clear");
		$display("test slave done");
		mode_pin <= 1'b1;
		presetn <= 1'b0;
		repeat (RESET_MIN_CYCLES) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(OFS_BUS_STAT, 8'h01, "expanded");
		core(1'b0, 1'b1, 16'h1234, 8'h00);
		`CHK("far read data", 8'h34 ^ 8'h5A, crd)
		`CHK("read strobes", 3'b100, {sr, sw, sl})
		`CHK("read addr", 16'h1234, {ahi, alo})
		`CHK("read bus oe", 8'h00, p2o)
		`CHK("fetch flag", 1'b1, sf)
		core(1'b1, 1'b0, 16'h1256, 8'h77);
		`CHK("write strobes", 3'b011, {sr, sw, sl})
		`CHK("write bus oe", 8'hFF, p2o)
		`CHK("no fetch flag", 1'b0, sf)
		`CHK("rw idle", 1'b1, read_write_out)
		core(1'b0, 1'b0, 16'hAB56, 8'h00);
		`CHK("read back", 8'h77, crd)
		`CHK("read back addr", 16'hAB56, {ahi, alo})
		$display("test expanded done");
		stop_test();
	end
endmodule // external_bus_pin_control_test
`undef CHK
`default_nettype wire
